// [hw/rom_clk_consts.vh]
// Offsets, field positions, reset values and timing counts of the bank
`ifndef ROM_CLK_CONSTS_VH
`define ROM_CLK_CONSTS_VH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define ROM_CONFIG_CONTROL_OFS 32'h0A000000
`define UNIT_CLOCK_GATE_OFS 32'h0A000004
`define ROM_ACCESS_TIMING_OFS 32'h0A00000C

// ---------------------------------------------------------------
// Reset values and writable masks
// ---------------------------------------------------------------
`define ROM_CONFIG_RESET 16'h8000
`define ROM_CONFIG_MASK 16'hC017
`define CLOCK_GATE_RESET 16'h0000
`define CLOCK_GATE_MASK 16'h007E
`define ACCESS_TIMING_RESET 16'h700F
`define ACCESS_TIMING_MASK 16'h700F

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define ROM_SIZE_HI 15
`define ROM_SIZE_LO 14
`define FLASH_WE_BIT 4
`define ROM_TYPE_HI 2
`define ROM_TYPE_LO 1
`define RESET_OUT_BIT 0
`define SERIAL_CLOCKED_PCLK_BIT 6
`define AUDIO_PCLK_BIT 5
`define TOUCH_PCLK_BIT 4
`define CONVERTER_PCLK_BIT 3
`define UART_REF_CLK_BIT 2
`define CONVERTER_REF_CLK_BIT 1
`define PAGE_WAIT_HI 14
`define PAGE_WAIT_LO 12
`define ROM_WAIT_HI 3
`define ROM_WAIT_LO 0

// ---------------------------------------------------------------
// Field encodings
// ---------------------------------------------------------------
`define SIZE_32MBIT 2'h1
`define SIZE_64MBIT 2'h2
`define TYPE_ORDINARY 2'h0
`define TYPE_FLASH 2'h1
`define TYPE_PAGE 2'h2

// ---------------------------------------------------------------
// Timing: access time in half peripheral-clock periods
// ---------------------------------------------------------------
`define PERIPH_DIV_RESET 2
`define ACCESS_BASE_HALVES 6'h03
`define ACCESS_STEP_HALVES 6'h02
`define PAGE_BURST_MAX 8

`endif

// [hw/rom_access_timer.v]
// Down counter that times one ROM access phase
`timescale 1ns/1ps
module rom_access_timer (
  input wire clk,
  input wire rst,
  input wire load,
  input wire [5:0] loadCount,
  output wire expire,
  output wire busy
);

  reg [5:0] count_reg;
  reg [5:0] count_next;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  always @* begin
    count_next = count_reg;
    if (load) begin
      count_next = loadCount;
    end else if (count_reg != 6'h00) begin
      count_next = count_reg - 6'h01;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= 6'h00;
    end else begin
      count_reg <= count_next;
    end
  end

  // Last cycle of the phase
  assign expire = (count_reg == 6'h01);
  assign busy = (count_reg != 6'h00);

endmodule

// [hw/rom_bank_decode.v]
// Maps a ROM-space address to one of four banks by the size setting
`timescale 1ns/1ps
`include "rom_clk_consts.vh"
module rom_bank_decode (
  input wire [24:0] addr,
  input wire [1:0] romSizeSel,
  output reg [3:0] bankSel,
  output reg inRange
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // One size for all four banks, so no per-bank base registers
  always @* begin
    bankSel = 4'h0;
    inRange = 1'b0;
    case (romSizeSel)
      `SIZE_32MBIT: begin
        // 4 MB banks in the upper half; lower half unused
        inRange = addr[24];
        if (addr[24]) begin
          bankSel = 4'h1 << addr[23:22];
        end
      end
      `SIZE_64MBIT: begin
        inRange = 1'b1;
        bankSel = 4'h1 << addr[24:23];
      end
      default: begin
        // Reserved sizes select nothing
        inRange = 1'b0;
      end
    endcase
  end

endmodule

// [hw/rom_and_clock_gate_regs.v]
// ROM configuration, unit clock gate and ROM timing registers with engine
// Function
// R1: Size field picks 32 or 64 Mbit
// R2: Reserved bits always read back zero
// R3: Flash write-enable bit gates write strobe
// R4: Type field picks ordinary, flash, page ROM
// R5: Software sets flash type and enable first
// R6: Software avoids ROM writes unless flash type
// R7: Control bit low drives reset pin low
// R8: Control bit ignored when pin is GPIO
// R9: Type and size shared by four banks
// R10: Bits six to three gate peripheral clocks
// R11: Bits two and one gate reference clock
// R12: Clock gate bit zero written, read zero
// R13: Page wait 1.5 to 8.5 cycles
// R14: ROM wait 1.5 to 16.5 cycles
// R15: Access timing shared by four banks
// R16: Page burst at most eight halfwords
// R17: Peripheral clock starts at core half rate
// R18: Hibernate exit restores all reset values
// R19: Reset output asserted until software releases
`timescale 1ns/1ps
`include "rom_clk_consts.vh"
module rom_and_clock_gate_regs (
  input wire clk,
  input wire rst,
  input wire hibernateExit,
  input wire [31:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [15:0] regWrData,
  output reg [15:0] regRdData,
  output reg regRdValid,
  input wire romReq,
  input wire romWrite,
  input wire [24:0] romAddr,
  input wire [2:0] romBurstLen,
  output reg romBusy,
  output reg romBeat,
  output reg romDone,
  output reg romReject,
  output reg [24:0] romAddrOut,
  output reg [3:0] romCsN,
  output reg romOeN,
  output reg romWeN,
  input wire sharedPinIsReset,
  input wire gpioOut,
  input wire gpioOe,
  output reg sharedPinOut,
  output reg sharedPinOe,
  output reg serialClockedPclkEn,
  output reg audioPclkEn,
  output reg touchPclkEn,
  output reg converterPclkEn,
  output reg uartRefClkEn,
  output reg converterRefClkEn,
  output reg periphClk
);

  // ---------------------------------------------------------------
  // Local definitions
  // ---------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_FIRST = 2'h1;
  localparam ST_PAGE = 2'h2;
  localparam ST_FINISH = 2'h3;

  // Half periph_clk periods; one clk cycle is half a periph_clk period
  function [5:0] waitHalves;
    input [3:0] code;
    begin
      waitHalves = `ACCESS_BASE_HALVES + {1'b0, code, 1'b0};
    end
  endfunction

  reg [15:0] romConfig_reg;
  reg [15:0] clockGate_reg;
  reg [15:0] accessTiming_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [24:0] romAddrOut_next;
  reg [2:0] beatsLeft_reg;
  reg [2:0] beatsLeft_next;
  reg isWrite_reg;
  reg isWrite_next;
  reg [3:0] romCsN_next;
  reg romOeN_next;
  reg romWeN_next;
  reg romBeat_next;
  reg romDone_next;
  reg romReject_next;
  reg timerLoad;
  reg [5:0] timerCount;
  reg [15:0] rdMux;

  wire selConfig;
  wire selGate;
  wire selTiming;
  wire [1:0] romType;
  wire [1:0] romSizeSel;
  wire flashWriteEnable;
  wire writeAllowed;
  wire pageMode;
  wire [3:0] romWait;
  wire [3:0] pageRomWait;
  wire [3:0] bankSel;
  wire bankInRange;
  wire timerExpire;

  assign selConfig = (regAddr == `ROM_CONFIG_CONTROL_OFS);
  assign selGate = (regAddr == `UNIT_CLOCK_GATE_OFS);
  assign selTiming = (regAddr == `ROM_ACCESS_TIMING_OFS);

  assign romSizeSel = romConfig_reg[`ROM_SIZE_HI:`ROM_SIZE_LO]; // R1
  assign romType = romConfig_reg[`ROM_TYPE_HI:`ROM_TYPE_LO]; // R4
  assign flashWriteEnable = romConfig_reg[`FLASH_WE_BIT];
  // Writes outside flash type are dropped rather than left undefined
  assign writeAllowed = flashWriteEnable && (romType == `TYPE_FLASH); // R3
  assign pageMode = (romType == `TYPE_PAGE); // R4
  assign romWait = accessTiming_reg[`ROM_WAIT_HI:`ROM_WAIT_LO];
  assign pageRomWait = {1'b0,
    accessTiming_reg[`PAGE_WAIT_HI:`PAGE_WAIT_LO]};

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  // Contents are lost in hibernate, so its exit reloads reset values
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      romConfig_reg <= `ROM_CONFIG_RESET; // R19
      clockGate_reg <= `CLOCK_GATE_RESET;
      accessTiming_reg <= `ACCESS_TIMING_RESET;
    end else if (hibernateExit) begin
      romConfig_reg <= `ROM_CONFIG_RESET; // R18
      clockGate_reg <= `CLOCK_GATE_RESET; // R18
      accessTiming_reg <= `ACCESS_TIMING_RESET; // R18
    end else if (regWrite) begin
      if (selConfig) begin
        romConfig_reg <= regWrData & `ROM_CONFIG_MASK; // R2
      end
      if (selGate) begin
        clockGate_reg <= regWrData & `CLOCK_GATE_MASK; // R12
      end
      if (selTiming) begin
        accessTiming_reg <= regWrData & `ACCESS_TIMING_MASK; // R2
      end
    end
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  always @* begin
    rdMux = 16'h0000;
    if (selConfig) begin
      rdMux = romConfig_reg;
    end else if (selGate) begin
      rdMux = clockGate_reg;
    end else if (selTiming) begin
      rdMux = accessTiming_reg;
    end
  end

  // Unmapped offsets read as zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData <= 16'h0000;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      if (regRead) begin
        regRdData <= rdMux; // R2
      end
    end
  end

  // ---------------------------------------------------------------
  // Clock gates and peripheral clock
  // ---------------------------------------------------------------
  // Enables only; the gating cells sit beside each unit
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      serialClockedPclkEn <= 1'b0;
      audioPclkEn <= 1'b0;
      touchPclkEn <= 1'b0;
      converterPclkEn <= 1'b0;
      uartRefClkEn <= 1'b0;
      converterRefClkEn <= 1'b0;
      periphClk <= 1'b0;
    end else begin
      serialClockedPclkEn <= clockGate_reg[`SERIAL_CLOCKED_PCLK_BIT]; // R10
      audioPclkEn <= clockGate_reg[`AUDIO_PCLK_BIT]; // R10
      touchPclkEn <= clockGate_reg[`TOUCH_PCLK_BIT]; // R10
      converterPclkEn <= clockGate_reg[`CONVERTER_PCLK_BIT]; // R10
      uartRefClkEn <= clockGate_reg[`UART_REF_CLK_BIT]; // R11
      converterRefClkEn <= clockGate_reg[`CONVERTER_REF_CLK_BIT]; // R11
      // Fixed divide by two; other ratios live outside this bank
      periphClk <= ~periphClk; // R17
    end
  end

  // ---------------------------------------------------------------
  // Shared reset pin
  // ---------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sharedPinOut <= 1'b0;
      sharedPinOe <= 1'b0;
    end else if (sharedPinIsReset) begin
      sharedPinOut <= romConfig_reg[`RESET_OUT_BIT]; // R7
      sharedPinOe <= 1'b1;
    end else begin
      sharedPinOut <= gpioOut; // R8
      sharedPinOe <= gpioOe; // R8
    end
  end

  // ---------------------------------------------------------------
  // ROM access engine
  // ---------------------------------------------------------------
  rom_bank_decode bankDecode (
    .addr(romAddr),
    .romSizeSel(romSizeSel),
    .bankSel(bankSel), // R9
    .inRange(bankInRange)
  );

  rom_access_timer accessTimer (
    .clk(clk),
    .rst(rst),
    .load(timerLoad),
    .loadCount(timerCount),
    .expire(timerExpire),
    .busy()
  );

  always @* begin
    state_next = state_reg;
    romAddrOut_next = romAddrOut;
    beatsLeft_next = beatsLeft_reg;
    isWrite_next = isWrite_reg;
    romCsN_next = romCsN;
    romOeN_next = romOeN;
    romWeN_next = romWeN;
    romBeat_next = 1'b0;
    romDone_next = 1'b0;
    romReject_next = 1'b0;
    timerLoad = 1'b0;
    timerCount = waitHalves(romWait); // R14 R15
    case (state_reg)
      ST_IDLE: begin
        if (romReq) begin
          if (!bankInRange || (romWrite && !writeAllowed)) begin
            romReject_next = 1'b1; // R3
          end else begin
            state_next = ST_FIRST;
            timerLoad = 1'b1;
            romAddrOut_next = romAddr;
            isWrite_next = romWrite;
            // Three-bit length caps a burst at eight halfwords
            beatsLeft_next = romWrite ? 3'h0 : romBurstLen; // R16
            romCsN_next = ~bankSel;
            romOeN_next = romWrite;
            romWeN_next = ~romWrite; // R3
          end
        end
      end
      ST_FIRST, ST_PAGE: begin
        if (timerExpire) begin
          romBeat_next = 1'b1;
          if (beatsLeft_reg == 3'h0) begin
            state_next = ST_FINISH;
            romCsN_next = 4'hF;
            romOeN_next = 1'b1;
            romWeN_next = 1'b1;
          end else begin
            state_next = ST_PAGE;
            beatsLeft_next = beatsLeft_reg - 3'h1;
            romAddrOut_next = romAddrOut + 25'h0000001;
            timerLoad = 1'b1;
            if (pageMode) begin
              timerCount = waitHalves(pageRomWait); // R13 R15
            end
          end
        end
      end
      ST_FINISH: begin
        romDone_next = 1'b1;
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      romAddrOut <= 25'h0000000;
      beatsLeft_reg <= 3'h0;
      isWrite_reg <= 1'b0;
      romCsN <= 4'hF;
      romOeN <= 1'b1;
      romWeN <= 1'b1;
      romBeat <= 1'b0;
      romDone <= 1'b0;
      romReject <= 1'b0;
      romBusy <= 1'b0;
    end else begin
      state_reg <= state_next;
      romAddrOut <= romAddrOut_next;
      beatsLeft_reg <= beatsLeft_next;
      isWrite_reg <= isWrite_next;
      romCsN <= romCsN_next;
      romOeN <= romOeN_next;
      romWeN <= romWeN_next;
      romBeat <= romBeat_next;
      romDone <= romDone_next;
      romReject <= romReject_next;
      romBusy <= (state_next != ST_IDLE);
    end
  end

endmodule

// [tb/rom_clock_gate_properties.sv]
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
`include "rom_clk_consts.vh"
module rom_clock_gate_checker (
  input wire clk,
  input wire rst,
  input wire hibernateExit,
  input wire [31:0] regAddr,
  input wire regWrite,
  input wire regRead,
  input wire [15:0] regWrData,
  input wire [15:0] regRdData,
  input wire regRdValid,
  input wire romBeat,
  input wire romDone,
  input wire romReject,
  input wire [3:0] romCsN,
  input wire romWeN,
  input wire sharedPinIsReset,
  input wire gpioOut,
  input wire gpioOe,
  input wire sharedPinOut,
  input wire sharedPinOe,
  input wire serialClockedPclkEn,
  input wire audioPclkEn,
  input wire touchPclkEn,
  input wire converterPclkEn,
  input wire uartRefClkEn,
  input wire converterRefClkEn,
  input wire periphClk
);
  // ----
  // Beat counter per access
  // ----
  reg [3:0] beatCnt;
  always @(posedge clk or posedge rst) begin
    if (rst)
      beatCnt <= 4'h0;
    else if (romDone)
      beatCnt <= 4'h0;
    else if (romBeat)
      beatCnt <= beatCnt + 4'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  gate_enable_a: assert property (
    regWrite && !hibernateExit && regAddr == `UNIT_CLOCK_GATE_OFS |-> ##2
    {serialClockedPclkEn, audioPclkEn, touchPclkEn, converterPclkEn,
    uartRefClkEn, converterRefClkEn} == $past(regWrData[6:1], 2))
    else $error("clock enables differ from written gate bits");
  read_answer_a: assert property (regRead |=> regRdValid)
    else $error("read not answered next cycle");
  cfg_reserved_a: assert property (
    regRdValid && $past(regAddr) == `ROM_CONFIG_CONTROL_OFS
    |-> (regRdData & 16'h3FE8) == 16'h0000)
    else $error("config reserved bits read nonzero");
  gate_reserved_a: assert property (
    regRdValid && $past(regAddr) == `UNIT_CLOCK_GATE_OFS
    |-> (regRdData & 16'hFF81) == 16'h0000)
    else $error("gate reserved bits read nonzero");
  timing_reserved_a: assert property (
    regRdValid && $past(regAddr) == `ROM_ACCESS_TIMING_OFS
    |-> (regRdData & 16'h8FF0) == 16'h0000)
    else $error("timing reserved bits read nonzero");
  reject_quiet_a: assert property (
    romReject |-> romCsN == 4'hF && romWeN)
    else $error("strobe during refused access");
  done_after_beat_a: assert property (
    romDone |-> $past(romBeat) && romCsN == 4'hF)
    else $error("done without closing beat");
  burst_limit_a: assert property (romBeat |-> beatCnt < 4'h8)
    else $error("more than eight beats");
  pin_follow_a: assert property (
    !sharedPinIsReset |=> sharedPinOut == $past(gpioOut)
    && sharedPinOe == $past(gpioOe))
    else $error("general pin ignores its own drive");
  pin_ctrl_a: assert property (
    (regWrite && !hibernateExit && sharedPinIsReset
    && regAddr == `ROM_CONFIG_CONTROL_OFS)
    ##1 (sharedPinIsReset && !regWrite && !hibernateExit)
    |=> sharedPinOut == $past(regWrData[0], 2) && sharedPinOe)
    else $error("reset pin level differs from control bit");
  // First edge after reset has no toggle behind it yet
  periph_half_a: assert property (
    !$past(rst) |-> periphClk != $past(periphClk))
    else $error("peripheral clock not at half rate");
  cover property (romReject);
  cover property (romBeat ##5 romBeat);
  cover property (romDone && !romWeN);
endmodule

bind rom_and_clock_gate_regs rom_clock_gate_checker checkerInst (
  .clk(clk), .rst(rst), .hibernateExit(hibernateExit), .regAddr(regAddr),
  .regWrite(regWrite), .regRead(regRead), .regWrData(regWrData),
  .regRdData(regRdData), .regRdValid(regRdValid), .romBeat(romBeat),
  .romDone(romDone), .romReject(romReject), .romCsN(romCsN),
  .romWeN(romWeN), .sharedPinIsReset(sharedPinIsReset),
  .gpioOut(gpioOut), .gpioOe(gpioOe), .sharedPinOut(sharedPinOut),
  .sharedPinOe(sharedPinOe), .serialClockedPclkEn(serialClockedPclkEn),
  .audioPclkEn(audioPclkEn), .touchPclkEn(touchPclkEn),
  .converterPclkEn(converterPclkEn), .uartRefClkEn(uartRefClkEn),
  .converterRefClkEn(converterRefClkEn), .periphClk(periphClk));

// [tb/rom_bank_model.sv]
// External ROM banks seen through their selects and strobes
`timescale 1ns/1ps
module rom_bank_model (
  input wire clk,
  input wire [3:0] romCsN,
  input wire romWeN,
  output reg [1:0] lastBank,
  output reg [7:0] writeCount
);
  reg idleD;
  reg weD;
  initial begin
    lastBank = 2'h0;
    writeCount = 8'h00;
    idleD = 1'b1;
    weD = 1'b1;
  end
  // Bank is known only at select start; later glitches are not seen
  always @(posedge clk) begin
    if (idleD && romCsN != 4'hF)
      lastBank <= !romCsN[3] ? 2'h3 : !romCsN[2] ? 2'h2 :
        !romCsN[1] ? 2'h1 : 2'h0;
    if (weD && !romWeN)
      writeCount <= writeCount + 8'h01;
    idleD <= (romCsN == 4'hF);
    weD <= romWeN;
  end
endmodule

// [tb/testbench.sv]
// Bank testbench: register access, pin control and ROM cycles
`timescale 1ns/1ps
`include "rom_clk_consts.vh"
module testbench;
  reg clk, rst, hibernateExit, regWrite, regRead, romReq, romWrite;
  reg sharedPinIsReset, gpioOut, gpioOe, rej;
  reg [31:0] regAddr;
  reg [15:0] regWrData, rd;
  reg [24:0] romAddr, lastAddr;
  reg [2:0] romBurstLen, strobes;
  wire [15:0] regRdData;
  wire regRdValid, romBusy, romBeat, romDone, romReject, romOeN, romWeN;
  wire sharedPinOut, sharedPinOe, periphClk;
  wire [5:0] clkEn;
  wire [3:0] romCsN;
  wire [24:0] romAddrOut;
  wire [1:0] lastBank;
  wire [7:0] writeCount;
  integer errTotal, nCompared, cyc, i, firstBeat, lastBeat, beats, t;
  reg [31:0] addrs [0:3];
  reg [15:0] rstVal [0:3];
  reg [15:0] maskVal [0:3];
  rom_and_clock_gate_regs rom_and_clock_gate_regs_inst (
    .clk(clk), .rst(rst), .hibernateExit(hibernateExit),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .romReq(romReq), .romWrite(romWrite), .romAddr(romAddr),
    .romBurstLen(romBurstLen), .romBusy(romBusy), .romBeat(romBeat),
    .romDone(romDone), .romReject(romReject), .romAddrOut(romAddrOut),
    .romCsN(romCsN), .romOeN(romOeN), .romWeN(romWeN),
    .sharedPinIsReset(sharedPinIsReset), .gpioOut(gpioOut),
    .gpioOe(gpioOe), .sharedPinOut(sharedPinOut), .sharedPinOe(sharedPinOe),
    .serialClockedPclkEn(clkEn[5]), .audioPclkEn(clkEn[4]),
    .touchPclkEn(clkEn[3]), .converterPclkEn(clkEn[2]),
    .uartRefClkEn(clkEn[1]), .converterRefClkEn(clkEn[0]),
    .periphClk(periphClk));
  rom_bank_model rom_bank_model_inst (.clk(clk), .romCsN(romCsN),
    .romWeN(romWeN), .lastBank(lastBank), .writeCount(writeCount));
  always #2.5 clk = ~clk;
  // ----
  // Access tasks
  // ----
  task chk(input [127:0] got, input [127:0] exp);
    begin
      nCompared = nCompared + 1;
      if (got !== exp) begin
        errTotal = errTotal + 1;
        $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task regWr(input [31:0] a, input [15:0] d);
    begin
      regAddr = a;
      regWrData = d;
      regWrite = 1'b1;
      @(negedge clk);
      regWrite = 1'b0;
      @(negedge clk);
    end
  endtask
  task regRd(input [31:0] a);
    begin
      regAddr = a;
      regRead = 1'b1;
      @(negedge clk);
      regRead = 1'b0;
      @(negedge clk);
      rd = regRdData;
    end
  endtask
  // Beat times counted in cycles after the accepting edge
  task romOp(input w, input [24:0] a, input [2:0] l);
    begin
      romWrite = w;
      romAddr = a;
      romBurstLen = l;
      romReq = 1'b1;
      @(negedge clk);
      romReq = 1'b0;
      t = 0;
      beats = 0;
      firstBeat = 0;
      lastBeat = 0;
      while (romDone !== 1'b1 && romReject !== 1'b1 && t < 200) begin
        @(negedge clk);
        t = t + 1;
        if (t == 1)
          strobes = {romBusy, romOeN, romWeN};
        if (romBeat === 1'b1) begin
          if (beats == 0)
            firstBeat = t;
          lastBeat = t;
          lastAddr = romAddrOut;
          beats = beats + 1;
        end
      end
      rej = (romReject === 1'b1);
      chk(t < 200, 1'b1);
      @(negedge clk);
    end
  endtask
  task results;
    begin
      $display("Compared %0d, mismatches %0d", nCompared, errTotal);
      if (errTotal == 0 && nCompared > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // Whole run is well under a thousand cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      errTotal = errTotal + 1;
      results;
    end
  end
  // ----
  // Main sequence
  // ----
  initial begin
    {clk, hibernateExit, regWrite, regRead, romReq, romWrite} = 6'h00;
    {gpioOut, gpioOe, regAddr, regWrData, romAddr, romBurstLen} = 0;
    rst = 1'b1;
    sharedPinIsReset = 1'b1;
    {errTotal, nCompared, cyc} = 0;
    addrs[0] = `ROM_CONFIG_CONTROL_OFS;
    addrs[1] = `UNIT_CLOCK_GATE_OFS;
    addrs[2] = `ROM_ACCESS_TIMING_OFS;
    addrs[3] = 32'h0A000008;
    {rstVal[0], rstVal[1], rstVal[2], rstVal[3]} = 64'h8000_0000_700F_0000;
    {maskVal[0], maskVal[1], maskVal[2], maskVal[3]} = 64'hC017_007E_700F_0000;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk({sharedPinOut, sharedPinOe}, 2'h1);
    for (i = 0; i < 4; i = i + 1) begin
      regRd(addrs[i]);
      chk(rd, rstVal[i]);
      regWr(addrs[i], (i == 1) ? 16'hFFFE : 16'hFFFF);
      regRd(addrs[i]);
      chk(rd, maskVal[i]);
    end
    chk(clkEn, 6'h3F);
    chk({sharedPinOut, sharedPinOe}, 2'h3);
    sharedPinIsReset = 1'b0;
    gpioOe = 1'b1;
    repeat (2) @(negedge clk);
    chk({sharedPinOut, sharedPinOe}, 2'h1);
    sharedPinIsReset = 1'b1;
    hibernateExit = 1'b1;
    @(negedge clk);
    hibernateExit = 1'b0;
    regRd(addrs[0]);
    chk(rd, 16'h8000);
    chk(clkEn, 6'h00);
    regWr(addrs[2], 16'h1000);
    regWr(addrs[0], 16'h8005);
    romOp(1'b0, 25'h1800000, 3'h2);
    chk({firstBeat, lastBeat, beats}, {32'd3, 32'd13, 32'd3});
    chk({strobes, lastAddr}, {3'h5, 25'h1800002});
    chk(lastBank, 2'h3);
    romOp(1'b0, 25'h1800000, 3'h7);
    chk({lastBeat, beats, lastAddr}, {32'd38, 32'd8, 25'h1800007});
    regWr(addrs[2], 16'h0002);
    regWr(addrs[0], 16'h8001);
    romOp(1'b0, 25'h0000000, 3'h1);
    chk({firstBeat, lastBeat, lastBank}, {32'd7, 32'd14, 2'h0});
    chk(lastAddr, 25'h0000001);
    regWr(addrs[0], 16'h8003);
    romOp(1'b1, 25'h0800000, 3'h0);
    chk(rej, 1'b1);
    regWr(addrs[0], 16'h8013);
    romOp(1'b1, 25'h0800000, 3'h0);
    chk({rej, writeCount, lastBank, strobes}, {1'b0, 8'h01, 2'h1, 3'h6});
    regWr(addrs[0], 16'h4001);
    romOp(1'b0, 25'h0400000, 3'h0);
    chk(rej, 1'b1);
    romOp(1'b0, 25'h1C00000, 3'h0);
    chk({rej, lastBank}, {1'b0, 2'h3});
    results;
  end
endmodule
